//--- hw/irq_pkg.sv
/*
 * Shared constants and types for the interrupt routing and non-maskable
 * request merge block. It assumes an 8-bit I/O port bus with one-cycle
 * read and write strobes, synchronous to the single system clock.
 */
// Notes on behaviour
// [R1] Accept up to seven GPIO interrupt inputs.
// [R2] Sources sharing a line are ORed.
// [R3] No conflict detection; software avoids conflicts.
// [R4] Primary controller 20H-21H, secondary A0H-A1H.
// [R5] Line 0 is only timer channel 0.
// [R6] Line 2 carries only the cascade.
// [R7] Line 1: pins, keyboard unit, GPIO.
// [R8] Lines 3,4: pins, serial, GPIO, card.
// [R9] Line 5: pins, GPIO, card, no serial.
// [R10] Line 6: pins or GPIO only.
// [R11] Line 7: pins, serial, GPIO, card.
// [R12] Line 9 alarm plus GPIO; 8 unused.
// [R13] Lines 10-15 GPIO/card; 13 GPIO only.
// [R14] Each NMI source masked inside its unit.
// [R15] NMI output is OR of unmasked requests.
// [R16] NMI source status readable at 19H.
// [R17] NMI sources: power, keyboard, chip selects.
// [R18] Each NMI cleared by its own unit.
// [R19] Timer channel 0 drives line 0.
// [R20] Timer channel 2 drives the speaker.
// [R21] Index port 026H, data port 027H.
// [R22] Routing 0DH, shadows 40H and 41H.
// [R23] Each pin routes to line 1-7 except 2.
// [R24] Cascaded controller pair, standard programming model.
// [R25] Unassigned lines stay inactive.
package irq_pkg;

	// ==========================================================
	// I/O map
	localparam logic [15:0] IO_PIC_PRI = 16'h0020;
	localparam logic [15:0] IO_PIC_SEC = 16'h00A0;
	localparam logic [15:0] IO_INDEX   = 16'h0026;
	localparam logic [15:0] IO_DATA    = 16'h0027;
	localparam logic [7:0]  IO_IDLE_RD = 8'hFF;

	// ==========================================================
	// Indexed registers
	localparam logic [7:0] IDX_ROUTE = 8'h0D;
	localparam logic [7:0] IDX_NMI   = 8'h19;
	localparam logic [7:0] IDX_CS0   = 8'h20;
	localparam logic [7:0] IDX_CS1   = 8'h24;
	localparam logic [7:0] IDX_CS2   = 8'h28;
	localparam logic [7:0] IDX_SHPRI = 8'h40;
	localparam logic [7:0] IDX_SHSEC = 8'h41;
	localparam logic [7:0] INDEX_RST = 8'h00;

	// ==========================================================
	// Fields and reset values
	localparam int          ROUTE_A_LSB  = 0;
	localparam int          ROUTE_B_LSB  = 4;
	localparam logic [7:0]  ROUTE_RST    = 8'h00;
	localparam int          CS_NMI_EN    = 0;
	localparam int          CS_NMI_CLR   = 7;
	localparam logic [6:0]  CS_MODE_RST  = 7'h00;
	localparam int          NMI_PMU_BIT  = 0;
	localparam int          NMI_KBD_BIT  = 1;
	localparam int          NMI_CS_LSB   = 2;
	localparam logic [7:0]  IMR_RST      = 8'hFF;

	// ==========================================================
	// Line numbers and per-source allowed-line masks
	localparam int          LINE_TIMER   = 0;
	localparam int          LINE_CASCADE = 2;
	localparam int          LINE_RTC     = 9;
	localparam logic [15:0] ALLOW_PIN    = 16'h00FA;
	localparam logic [15:0] ALLOW_KBD    = 16'h0002;
	localparam logic [15:0] ALLOW_SER    = 16'h0098;
	localparam logic [15:0] ALLOW_CARD   = 16'hDCB8;
	localparam logic [15:0] ALLOW_GPIO   = 16'hFEFA;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		IRQ_ST_ICW2  = 2'b00,
		IRQ_ST_ICW3  = 2'b01,
		IRQ_ST_ICW4  = 2'b10,
		IRQ_ST_READY = 2'b11
	} irq_init_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} irq_io_req_t;

	typedef struct packed {
		logic       wr;
		logic       a0;
		logic [7:0] data;
	} irq_pic_acc_t;

endpackage

//--- hw/irq_route_top.sv
/*
 * Interrupt routing, a cascaded controller pair and the NMI merge.
 * Assumes the CPU issues one inta pulse per acknowledge and that the
 * timer, keyboard, power and serial units are outside this file.
 */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// One programmable interrupt controller
module irq_pic (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire irq_pkg::irq_pic_acc_t acc,
	input  wire logic [7:0]            irq_in,
	input  wire logic                  ack,
	output logic                       int_req,
	output logic [2:0]                 top_idx,
	output logic [7:0]                 vector,
	output logic [7:0]                 rdata,
	output logic [7:0]                 shadow
);
	irq_pkg::irq_init_t step_reg;
	logic       ltim_reg;
	logic       sngl_reg;
	logic       ic4_reg;
	logic       aeoi_reg;
	logic       rd_isr_reg;
	logic [4:0] vbase_reg;
	logic [7:0] imr_reg;
	logic [7:0] irr_reg;
	logic [7:0] isr_reg;
	logic [7:0] prev_reg;
	logic [7:0] isr_next;
	logic [7:0] pend;
	logic [7:0] ack_mask;
	logic [7:0] eoi_clr;
	logic [2:0] isr_idx;
	logic       req_any;
	logic       isr_any;
	logic       icw1;
	logic       ocw2;
	logic       ocw3;

	// Line 0 has the highest priority.
	function automatic logic [2:0] first_set(input logic [7:0] v);
		first_set = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				first_set = 3'(i);
			end
		end
	endfunction

	always_comb begin
		pend     = irr_reg & ~imr_reg;
		req_any  = |pend;
		isr_any  = |isr_reg;
		top_idx  = first_set(pend);
		isr_idx  = first_set(isr_reg);
		int_req  = req_any && (step_reg == irq_pkg::IRQ_ST_READY)
			&& (!isr_any || top_idx < isr_idx); // [R24]
		vector   = {vbase_reg, top_idx};
		rdata    = acc.a0 ? imr_reg : (rd_isr_reg ? isr_reg : irr_reg);
		shadow   = {vbase_reg, 3'h0};
		icw1     = acc.wr && !acc.a0 && acc.data[4];
		ocw2     = acc.wr && !acc.a0 && !acc.data[4] && !acc.data[3];
		ocw3     = acc.wr && !acc.a0 && !acc.data[4] && acc.data[3];
		ack_mask = ack ? (8'h01 << top_idx) : 8'h00;
		eoi_clr  = 8'h00;
		if (ocw2 && acc.data[5]) begin
			if (acc.data[6]) begin
				eoi_clr = 8'h01 << acc.data[2:0];
			end else if (isr_any) begin
				eoi_clr = 8'h01 << isr_idx;
			end
		end
		isr_next = (isr_reg & ~eoi_clr) | (aeoi_reg ? 8'h00 : ack_mask);
	end

	// Initialisation word sequence.
	always_ff @(posedge clk) begin
		if (rst) begin
			step_reg  <= irq_pkg::IRQ_ST_READY;
			ltim_reg  <= 1'b0;
			sngl_reg  <= 1'b0;
			ic4_reg   <= 1'b0;
			aeoi_reg  <= 1'b0;
			vbase_reg <= 5'h00;
		end else if (icw1) begin // [R24]
			step_reg <= irq_pkg::IRQ_ST_ICW2;
			ltim_reg <= acc.data[3];
			sngl_reg <= acc.data[1];
			ic4_reg  <= acc.data[0];
			aeoi_reg <= 1'b0;
		end else if (acc.wr && acc.a0) begin
			case (step_reg)
				irq_pkg::IRQ_ST_ICW2: begin
					vbase_reg <= acc.data[7:3];
					if (!sngl_reg) begin
						step_reg <= irq_pkg::IRQ_ST_ICW3;
					end else if (ic4_reg) begin
						step_reg <= irq_pkg::IRQ_ST_ICW4;
					end else begin
						step_reg <= irq_pkg::IRQ_ST_READY;
					end
				end
				// The cascade wiring is fixed, so the word is accepted unread.
				irq_pkg::IRQ_ST_ICW3: begin
					step_reg <= ic4_reg ? irq_pkg::IRQ_ST_ICW4
						: irq_pkg::IRQ_ST_READY;
				end
				irq_pkg::IRQ_ST_ICW4: begin
					aeoi_reg <= acc.data[1];
					step_reg <= irq_pkg::IRQ_ST_READY;
				end
				default: begin
					step_reg <= irq_pkg::IRQ_ST_READY;
				end
			endcase
		end
	end

	// Mask and read-select words.
	always_ff @(posedge clk) begin
		if (rst) begin
			imr_reg    <= irq_pkg::IMR_RST;
			rd_isr_reg <= 1'b0;
		end else if (icw1) begin
			imr_reg    <= 8'h00;
			rd_isr_reg <= 1'b0;
		end else begin
			if (acc.wr && acc.a0 && step_reg == irq_pkg::IRQ_ST_READY) begin
				imr_reg <= acc.data; // [R24]
			end
			if (ocw3 && acc.data[1]) begin
				rd_isr_reg <= acc.data[0];
			end
		end
	end

	// A rising edge in the acknowledge cycle is kept: set beats clear.
	always_ff @(posedge clk) begin
		if (rst) begin
			irr_reg  <= 8'h00;
			isr_reg  <= 8'h00;
			prev_reg <= 8'h00;
		end else begin
			prev_reg <= irq_in;
			if (icw1) begin
				irr_reg <= 8'h00;
				isr_reg <= 8'h00;
			end else begin
				irr_reg <= ltim_reg ? irq_in
					: ((irr_reg & ~ack_mask) | (irq_in & ~prev_reg));
				isr_reg <= isr_next;
			end
		end
	end
endmodule // irq_pic

// ==========================================================
// Routing, register port and NMI merge
module irq_route_top #(
	parameter int GPIO_IRQS = 7 // [R1]
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire irq_pkg::irq_io_req_t   io_req,
	output logic [7:0]                  io_rdata,
	input  wire logic                   timer0_out,
	input  wire logic                   timer2_out,
	input  wire logic                   ext_int_pin_a,
	input  wire logic                   ext_int_pin_b,
	input  wire logic                   keyboard_ctl_unit_irq,
	input  wire logic                   serial_port_unit_irq,
	input  wire logic [3:0]             serial_line,
	input  wire logic                   pccard_irq,
	input  wire logic [3:0]             pccard_line,
	input  wire logic                   rtc_alarm,
	input  wire logic [GPIO_IRQS-1:0]   gpio_irq,
	input  wire logic [4*GPIO_IRQS-1:0] gpio_line,
	input  wire logic                   power_mgmt_unit_nmi,
	input  wire logic                   keyboard_ctl_unit_nmi,
	input  wire logic [2:0]             prog_chip_select_evt,
	input  wire logic                   inta,
	output logic                        cpu_intr,
	output logic                        cpu_nmi,
	output logic [7:0]                  cpu_vector,
	output logic                        speaker_out
);
	logic [7:0]  index_reg;
	logic [7:0]  route_reg;
	logic [6:0]  cs_mode_reg [3];
	logic [2:0]  cs_pend_reg;
	logic [15:0] line_reg;
	logic [15:0] line_next;
	logic [15:0] gpio_dec [GPIO_IRQS];
	logic [7:0]  nmi_stat;
	logic [7:0]  rdata_next;
	logic [7:0]  pri_rd;
	logic [7:0]  sec_rd;
	logic [7:0]  pri_vec;
	logic [7:0]  sec_vec;
	logic [7:0]  pri_sh;
	logic [7:0]  sec_sh;
	logic [2:0]  pri_idx;
	logic        pri_int;
	logic        sec_int;
	logic        sec_ack;
	logic        pri_sel;
	logic        sec_sel;
	logic        data_wr;
	irq_pkg::irq_pic_acc_t pri_acc;
	irq_pkg::irq_pic_acc_t sec_acc;

	function automatic logic [15:0] line_dec(input logic [3:0] sel,
		input logic [15:0] allow);
		line_dec = (16'h0001 << sel) & allow;
	endfunction

	// ==========================================================
	// Request line assembly
	for (genvar g = 0; g < GPIO_IRQS; g++) begin : g_gpio
		assign gpio_dec[g] = gpio_irq[g]
			? line_dec(gpio_line[4*g +: 4], irq_pkg::ALLOW_GPIO) : 16'h0000; // [R13]
	end

	// Overlapping assignments are simply ORed; nothing arbitrates them.
	always_comb begin
		line_next = 16'h0000; // [R25]
		if (ext_int_pin_a) begin
			line_next |= line_dec({1'b0, route_reg[irq_pkg::ROUTE_A_LSB +: 3]},
				irq_pkg::ALLOW_PIN); // [R23]
		end
		if (ext_int_pin_b) begin
			line_next |= line_dec({1'b0, route_reg[irq_pkg::ROUTE_B_LSB +: 3]},
				irq_pkg::ALLOW_PIN); // [R23]
		end
		if (keyboard_ctl_unit_irq) begin
			line_next |= irq_pkg::ALLOW_KBD; // [R7]
		end
		if (serial_port_unit_irq) begin
			line_next |= line_dec(serial_line, irq_pkg::ALLOW_SER); // [R8] [R9] [R11]
		end
		if (pccard_irq) begin
			line_next |= line_dec(pccard_line, irq_pkg::ALLOW_CARD); // [R10] [R13]
		end
		for (int i = 0; i < GPIO_IRQS; i++) begin
			line_next |= gpio_dec[i]; // [R2] [R3]
		end
		line_next[irq_pkg::LINE_RTC] = line_next[irq_pkg::LINE_RTC] | rtc_alarm; // [R12]
		line_next[irq_pkg::LINE_TIMER] = timer0_out; // [R5] [R19]
		line_next[irq_pkg::LINE_CASCADE] = 1'b0; // [R6]
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			line_reg <= 16'h0000;
		end else begin
			line_reg <= line_next;
		end
	end

	// ==========================================================
	// I/O decode
	always_comb begin
		pri_sel = io_req.addr[15:1] == irq_pkg::IO_PIC_PRI[15:1]; // [R4]
		sec_sel = io_req.addr[15:1] == irq_pkg::IO_PIC_SEC[15:1]; // [R4]
		data_wr = io_req.wr && io_req.addr == irq_pkg::IO_DATA; // [R21]
		pri_acc = '{wr: io_req.wr && pri_sel, a0: io_req.addr[0],
			data: io_req.wdata};
		sec_acc = '{wr: io_req.wr && sec_sel, a0: io_req.addr[0],
			data: io_req.wdata};
	end

	// ==========================================================
	// Controller pair, secondary cascaded into primary input 2
	irq_pic u_pri (
		.clk     (clk),
		.rst     (rst),
		.acc     (pri_acc),
		.irq_in  ({line_reg[7:3], sec_int, line_reg[1:0]}), // [R6] [R24]
		.ack     (inta),
		.int_req (pri_int),
		.top_idx (pri_idx),
		.vector  (pri_vec),
		.rdata   (pri_rd),
		.shadow  (pri_sh)
	);

	assign sec_ack = inta && pri_idx == 3'(irq_pkg::LINE_CASCADE);

	irq_pic u_sec (
		.clk     (clk),
		.rst     (rst),
		.acc     (sec_acc),
		.irq_in  (line_reg[15:8]),
		.ack     (sec_ack),
		.int_req (sec_int),
		.top_idx (),
		.vector  (sec_vec),
		.rdata   (sec_rd),
		.shadow  (sec_sh)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_intr   <= 1'b0;
			cpu_vector <= 8'h00;
		end else begin
			cpu_intr <= pri_int;
			if (inta) begin
				cpu_vector <= sec_ack ? sec_vec : pri_vec; // [R24]
			end
		end
	end

	// ==========================================================
	// Index and configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			index_reg <= irq_pkg::INDEX_RST;
			route_reg <= irq_pkg::ROUTE_RST;
		end else begin
			if (io_req.wr && io_req.addr == irq_pkg::IO_INDEX) begin
				index_reg <= io_req.wdata; // [R21]
			end
			if (data_wr && index_reg == irq_pkg::IDX_ROUTE) begin
				route_reg <= io_req.wdata; // [R22]
			end
		end
	end

	// Chip-select NMI sources live here, so their mask and clear do too.
	for (genvar c = 0; c < 3; c++) begin : g_cs
		localparam logic [7:0] CS_IDX = 8'(irq_pkg::IDX_CS0 + 4 * c);
		logic cs_wr;
		assign cs_wr = data_wr && index_reg == CS_IDX;
		always_ff @(posedge clk) begin
			if (rst) begin
				cs_mode_reg[c] <= irq_pkg::CS_MODE_RST;
				cs_pend_reg[c] <= 1'b0;
			end else begin
				if (cs_wr) begin
					cs_mode_reg[c] <= io_req.wdata[6:0];
				end
				cs_pend_reg[c] <= prog_chip_select_evt[c]
					|| (cs_pend_reg[c]
					&& !(cs_wr && io_req.wdata[irq_pkg::CS_NMI_CLR])); // [R18]
			end
		end
	end

	// ==========================================================
	// NMI merge
	always_comb begin
		nmi_stat = 8'h00;
		nmi_stat[irq_pkg::NMI_PMU_BIT] = power_mgmt_unit_nmi; // [R14] [R17]
		nmi_stat[irq_pkg::NMI_KBD_BIT] = keyboard_ctl_unit_nmi; // [R14] [R17]
		for (int i = 0; i < 3; i++) begin
			nmi_stat[irq_pkg::NMI_CS_LSB + i] =
				cs_pend_reg[i] && cs_mode_reg[i][irq_pkg::CS_NMI_EN]; // [R14]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_nmi     <= 1'b0;
			speaker_out <= 1'b0;
		end else begin
			cpu_nmi     <= |nmi_stat; // [R15]
			speaker_out <= timer2_out; // [R20]
		end
	end

	// ==========================================================
	// Read data, registered one cycle after the read strobe
	always_comb begin
		rdata_next = irq_pkg::IO_IDLE_RD;
		if (pri_sel) begin
			rdata_next = pri_rd;
		end else if (sec_sel) begin
			rdata_next = sec_rd;
		end else if (io_req.addr == irq_pkg::IO_INDEX) begin
			rdata_next = index_reg;
		end else if (io_req.addr == irq_pkg::IO_DATA) begin
			rdata_next = 8'h00;
			if (index_reg == irq_pkg::IDX_ROUTE) begin
				rdata_next = route_reg;
			end else if (index_reg == irq_pkg::IDX_NMI) begin
				rdata_next = nmi_stat; // [R16]
			end else if (index_reg == irq_pkg::IDX_CS0) begin
				rdata_next = {1'b0, cs_mode_reg[0]};
			end else if (index_reg == irq_pkg::IDX_CS1) begin
				rdata_next = {1'b0, cs_mode_reg[1]};
			end else if (index_reg == irq_pkg::IDX_CS2) begin
				rdata_next = {1'b0, cs_mode_reg[2]};
			end else if (index_reg == irq_pkg::IDX_SHPRI) begin
				rdata_next = pri_sh; // [R22]
			end else if (index_reg == irq_pkg::IDX_SHSEC) begin
				rdata_next = sec_sh; // [R22]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			io_rdata <= 8'h00;
		end else if (io_req.rd) begin
			io_rdata <= rdata_next;
		end
	end
endmodule // irq_route_top

`default_nettype wire

//--- verification/irq_route_monitor.sv
/* Port-level assertions for irq_route_top.
   Assumes one clock and the synchronous active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module irq_route_monitor #(
	parameter int GPIO_IRQS = 7
) (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire irq_pkg::irq_io_req_t io_req,
	input wire logic [7:0]           io_rdata,
	input wire logic                 timer2_out,
	input wire logic                 speaker_out,
	input wire logic                 power_mgmt_unit_nmi,
	input wire logic                 keyboard_ctl_unit_nmi,
	input wire logic [2:0]           prog_chip_select_evt,
	input wire logic                 cpu_intr,
	input wire logic                 cpu_nmi
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic pic_wr_seen;
	logic data_wr_seen;
	// ========
	// Helpers
	// Both controllers come out of reset fully masked, so no request may pass before a write.
	always_ff @(posedge clk) begin
		if (rst)
			pic_wr_seen <= 1'b0;
		else if (io_req.wr && (io_req.addr[15:1] == 15'h0010 || io_req.addr[15:1] == 15'h0050))
			pic_wr_seen <= 1'b1;
	end
	always_ff @(posedge clk) begin
		if (rst)
			data_wr_seen <= 1'b0;
		else if (io_req.wr && io_req.addr == irq_pkg::IO_DATA)
			data_wr_seen <= 1'b1;
	end
	// ========
	// Properties
	sequence s_sel_blank;
		io_req.wr && io_req.addr == irq_pkg::IO_INDEX && io_req.wdata == 8'h01;
	endsequence
	sequence s_data_rd;
		io_req.rd && io_req.addr == irq_pkg::IO_DATA;
	endsequence
	property p_blank_index;
		s_sel_blank ##2 s_data_rd |=> io_rdata == 8'h00;
	endproperty
	property p_idle_read;
		io_req.rd && !(io_req.addr inside {16'h0020, 16'h0021, 16'h0026, 16'h0027,
			16'h00A0, 16'h00A1}) |=> io_rdata == irq_pkg::IO_IDLE_RD;
	endproperty
	property p_rd_hold;
		!io_req.rd |=> $stable(io_rdata);
	endproperty
	property p_speaker;
		$rose(timer2_out) |=> $rose(speaker_out);
	endproperty
	property p_nmi_pmu;
		power_mgmt_unit_nmi |=> cpu_nmi;
	endproperty
	property p_nmi_kbd;
		keyboard_ctl_unit_nmi |=> cpu_nmi;
	endproperty
	property p_nmi_quiet;
		!data_wr_seen && !power_mgmt_unit_nmi && !keyboard_ctl_unit_nmi |=> !cpu_nmi;
	endproperty
	property p_masked;
		!pic_wr_seen |-> !cpu_intr;
	endproperty
	property p_reset_quiet;
		$fell(rst) |-> !cpu_intr && !cpu_nmi && !speaker_out;
	endproperty
	a_blank_index: assert property (p_blank_index)
		else $error("blank index did not read zero");
	a_idle_read: assert property (p_idle_read)
		else $error("unmapped read not FF");
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved without a read");
	a_speaker: assert property (p_speaker)
		else $error("speaker did not follow timer 2");
	a_nmi_pmu: assert property (p_nmi_pmu)
		else $error("power nmi not merged");
	a_nmi_kbd: assert property (p_nmi_kbd)
		else $error("keyboard nmi not merged");
	a_nmi_quiet: assert property (p_nmi_quiet)
		else $error("nmi with all sources quiet");
	a_masked: assert property (p_masked)
		else $error("request passed a masked controller");
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("output active after reset");
endmodule // irq_route_monitor
`default_nettype wire

//--- verification/irq_cpu_model.sv
/* Behavioural CPU interrupt side: acknowledges requests and keeps the vector.
   Assumes cpu_vector is valid the edge after inta. */
`timescale 1ns/1ps
`default_nettype none
module irq_cpu_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       cpu_intr,
	input  wire logic [7:0] cpu_vector,
	input  wire logic [3:0] ack_delay,
	output logic            inta,
	output logic [7:0]      last_vec,
	output logic [7:0]      ack_count
);
	logic [3:0] wait_reg;
	logic [2:0] hold_reg;
	logic       taken_reg;
	// The hold-off covers the cycles cpu_intr needs to fall after an acknowledge.
	always_ff @(posedge clk) begin
		if (rst) begin
			inta     <= 1'b0;
			wait_reg <= 4'h0;
			hold_reg <= 3'h0;
		end else begin
			inta <= 1'b0;
			if (hold_reg != 3'h0)
				hold_reg <= hold_reg - 3'h1;
			else if (cpu_intr && wait_reg == ack_delay) begin
				inta     <= 1'b1;
				wait_reg <= 4'h0;
				hold_reg <= 3'h4;
			end else if (cpu_intr)
				wait_reg <= wait_reg + 4'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			taken_reg <= 1'b0;
			last_vec  <= 8'h00;
			ack_count <= 8'h00;
		end else begin
			taken_reg <= inta;
			if (taken_reg) begin
				last_vec  <= cpu_vector;
				ack_count <= ack_count + 8'h01;
			end
		end
	end
endmodule // irq_cpu_model
`default_nettype wire

//--- verification/irq_route_tb.sv
/* Self-checking bench for irq_route_top with the CPU model.
   Assumes the package and design are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [2:0] LINES [6] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	irq_pkg::irq_io_req_t io_req = '0;
	logic                 timer0_out = 1'b0;
	logic                 timer2_out = 1'b0;
	logic                 ext_int_pin_a = 1'b0;
	logic                 ext_int_pin_b = 1'b0;
	logic                 keyboard_ctl_unit_irq = 1'b0;
	logic                 serial_port_unit_irq = 1'b0;
	logic [3:0]           serial_line = 4'h4;
	logic                 pccard_irq = 1'b0;
	logic [3:0]           pccard_line = 4'h4;
	logic                 rtc_alarm = 1'b0;
	logic [6:0]           gpio_irq = 7'h00;
	logic [27:0]          gpio_line = 28'hD000000;
	logic                 power_mgmt_unit_nmi = 1'b0;
	logic                 keyboard_ctl_unit_nmi = 1'b0;
	logic [2:0]           prog_chip_select_evt = 3'h0;
	logic [3:0]           ack_delay = 4'h0;
	logic                 inta;
	logic [7:0]           io_rdata;
	logic [7:0]           cpu_vector;
	logic [7:0]           last_vec;
	logic [7:0]           ack_count;
	logic                 cpu_intr;
	logic                 cpu_nmi;
	logic                 speaker_out;
	int                   fail_count = 0;
	int                   total_checks = 0;
	always #10 clk = ~clk;
	irq_route_top #(.GPIO_IRQS(7)) DUT (.clk, .rst, .io_req, .io_rdata, .timer0_out,
		.timer2_out, .ext_int_pin_a, .ext_int_pin_b, .keyboard_ctl_unit_irq,
		.serial_port_unit_irq, .serial_line, .pccard_irq, .pccard_line, .rtc_alarm,
		.gpio_irq, .gpio_line, .power_mgmt_unit_nmi, .keyboard_ctl_unit_nmi,
		.prog_chip_select_evt, .inta, .cpu_intr, .cpu_nmi, .cpu_vector, .speaker_out);
	irq_cpu_model u_cpu (.clk, .rst, .cpu_intr, .cpu_vector, .ack_delay, .inta, .last_vec,
		.ack_count);
	// ========
	// Shared tasks
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// The strobe is dropped on the taking edge, so every access leaves one idle cycle.
	task automatic io_cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		io_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		io_req <= '0;
		#1;
	endtask
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		io_cyc(1'b1, irq_pkg::IO_INDEX, idx);
		io_cyc(1'b1, irq_pkg::IO_DATA, d);
	endtask
	task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp, input string m);
		io_cyc(1'b1, irq_pkg::IO_INDEX, idx);
		io_cyc(1'b0, irq_pkg::IO_DATA, 8'h00);
		chk(io_rdata, exp, m);
	endtask
	task automatic expect_ack(input logic [7:0] v, input logic want);
		logic [7:0] c0;
		int         n;
		c0 = ack_count;
		n = 0;
		while (ack_count === c0 && n < 40) begin
			@(posedge clk);
			n++;
		end
		#1;
		if (want && ack_count === c0) begin
			fail_count++;
			$display("CHECK FAILED t=%0t no acknowledge", $time);
			test_done();
		end
		if (want)
			chk(last_vec, v, "vector");
		chk({7'h0, ack_count !== c0}, {7'h0, want}, "ack seen");
	endtask
	task automatic pic_init(input logic [15:0] base, input logic [7:0] vb, input logic [7:0] cas);
		io_cyc(1'b1, base, 8'h11);
		io_cyc(1'b1, base + 16'h1, vb);
		io_cyc(1'b1, base + 16'h1, cas);
		io_cyc(1'b1, base + 16'h1, 8'h02);
		io_cyc(1'b1, base + 16'h1, 8'h00);
	endtask
	// ========
	// Scenarios
	task automatic t_regs;
		chk({6'h0, cpu_intr, cpu_nmi}, 8'h00, "idle outputs");
		reg_rd(irq_pkg::IDX_ROUTE, 8'h00, "route reset");
		reg_rd(irq_pkg::IDX_NMI, 8'h00, "status reset");
		reg_rd(irq_pkg::IDX_SHPRI, 8'h00, "shadow reset");
		reg_rd(8'h01, 8'h00, "blank index");
		reg_wr(irq_pkg::IDX_NMI, 8'h5A);
		reg_rd(irq_pkg::IDX_NMI, 8'h00, "status read only");
		reg_wr(irq_pkg::IDX_ROUTE, 8'h31);
		reg_rd(irq_pkg::IDX_ROUTE, 8'h31, "route rw");
		io_cyc(1'b0, 16'h0030, 8'h00);
		chk(io_rdata, irq_pkg::IO_IDLE_RD, "unmapped io");
		$display("t_regs done");
	endtask
	task automatic t_nmi;
		logic [7:0] idx;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			{keyboard_ctl_unit_nmi, power_mgmt_unit_nmi} <= 2'b01 << i;
			reg_rd(irq_pkg::IDX_NMI, 8'h01 << i, "unit status");
			chk({7'h0, cpu_nmi}, 8'h01, "unit nmi");
		end
		@(posedge clk);
		{keyboard_ctl_unit_nmi, power_mgmt_unit_nmi} <= 2'b00;
		for (int i = 0; i < 3; i++) begin
			idx = irq_pkg::IDX_CS0 + 8'(4 * i);
			@(posedge clk);
			prog_chip_select_evt <= 3'h1 << i;
			@(posedge clk);
			prog_chip_select_evt <= 3'h0;
			reg_rd(irq_pkg::IDX_NMI, 8'h00, "masked select");
			reg_wr(idx, 8'h81);
			reg_rd(idx, 8'h01, "select mode");
			@(posedge clk);
			prog_chip_select_evt <= 3'h1 << i;
			@(posedge clk);
			prog_chip_select_evt <= 3'h0;
			reg_rd(irq_pkg::IDX_NMI, 8'h04 << i, "select status");
			chk({7'h0, cpu_nmi}, 8'h01, "select nmi");
			reg_wr(idx, 8'h81);
			reg_rd(irq_pkg::IDX_NMI, 8'h00, "select cleared");
			chk({7'h0, cpu_nmi}, 8'h00, "nmi released");
			reg_wr(idx, 8'h00);
		end
		$display("t_nmi done");
	endtask
	task automatic t_pic;
		pic_init(irq_pkg::IO_PIC_PRI, 8'h08, 8'h04);
		pic_init(irq_pkg::IO_PIC_SEC, 8'h70, 8'h02);
		reg_rd(irq_pkg::IDX_SHPRI, 8'h08, "primary shadow");
		reg_rd(irq_pkg::IDX_SHSEC, 8'h70, "secondary shadow");
		@(posedge clk);
		timer0_out <= 1'b1;
		timer2_out <= 1'b1;
		expect_ack(8'h08, 1'b1);
		chk({7'h0, speaker_out}, 8'h01, "speaker");
		@(posedge clk);
		timer0_out <= 1'b0;
		timer2_out <= 1'b0;
		$display("t_pic done");
	endtask
	task automatic t_route;
		ack_delay <= 4'h9;
		for (int i = 0; i < 6; i++) begin
			reg_wr(irq_pkg::IDX_ROUTE, i[0] ? {1'b0, LINES[i], 4'h0} : {5'h0, LINES[i]});
			@(posedge clk);
			{ext_int_pin_b, ext_int_pin_a} <= i[0] ? 2'b10 : 2'b01;
			expect_ack(8'h08 + 8'(LINES[i]), 1'b1);
			@(posedge clk);
			{ext_int_pin_b, ext_int_pin_a} <= 2'b00;
		end
		reg_wr(irq_pkg::IDX_ROUTE, 8'h22);
		@(posedge clk);
		{ext_int_pin_b, ext_int_pin_a} <= 2'b11;
		expect_ack(8'h00, 1'b0);
		@(posedge clk);
		{ext_int_pin_b, ext_int_pin_a} <= 2'b00;
		ack_delay <= 4'h0;
		$display("t_route done");
	endtask
	task automatic t_share;
		@(posedge clk);
		serial_port_unit_irq <= 1'b1;
		expect_ack(8'h0C, 1'b1);
		@(posedge clk);
		pccard_irq <= 1'b1;
		expect_ack(8'h00, 1'b0);
		@(posedge clk);
		serial_port_unit_irq <= 1'b0;
		expect_ack(8'h00, 1'b0);
		@(posedge clk);
		pccard_irq <= 1'b0;
		serial_line <= 4'h5;
		pccard_line <= 4'hD;
		repeat (2) @(posedge clk);
		{serial_port_unit_irq, pccard_irq} <= 2'b11;
		expect_ack(8'h00, 1'b0);
		@(posedge clk);
		gpio_irq <= 7'h40;
		expect_ack(8'h75, 1'b1);
		@(posedge clk);
		rtc_alarm <= 1'b1;
		expect_ack(8'h71, 1'b1);
		io_cyc(1'b1, 16'h0021, 8'h02);
		io_cyc(1'b0, 16'h0021, 8'h00);
		chk(io_rdata, 8'h02, "primary mask");
		@(posedge clk);
		keyboard_ctl_unit_irq <= 1'b1;
		expect_ack(8'h00, 1'b0);
		io_cyc(1'b1, 16'h0021, 8'h00);
		expect_ack(8'h09, 1'b1);
		$display("t_share done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_nmi();
		t_pic();
		t_route();
		t_share();
		test_done();
	end
endmodule // testbench
bind irq_route_top irq_route_monitor #(.GPIO_IRQS(GPIO_IRQS)) u_mon (.clk, .rst, .io_req,
	.io_rdata, .timer2_out, .speaker_out, .power_mgmt_unit_nmi, .keyboard_ctl_unit_nmi,
	.prog_chip_select_evt, .cpu_intr, .cpu_nmi);
`default_nettype wire
